// file: hdl/crs_map.svh
// Register offsets, field positions, reset values and timing counts of the
// call and return sequencer. Included by the sequencer and the testbench; holds definitions only.
`ifndef CRS_MAP_SVH
`define CRS_MAP_SVH

`define CRS_OFS_CTRL 8'h00
`define CRS_OFS_STATUS 8'h04
`define CRS_OFS_ACC 8'h08
`define CRS_OFS_INDIRECT 8'h0C
`define CRS_OFS_RTC 8'h10
`define CRS_OFS_PC 8'h14

`define CRS_CTRL_TURBO 0
`define CRS_CTRL_EXTEND 1
`define CRS_CTRL_NARROW 2
`define CRS_CTRL_RESET 3'h2

`define CRS_PAGE_HI 7
`define CRS_PAGE_LO 5
`define CRS_PC_RESET 12'hFFF
`define CRS_PC_IRQ 12'h000
`define CRS_PC_NARROW_MASK 12'h7FF

`define CRS_CALL_CYC_COMPAT 2
`define CRS_CALL_CYC_TURBO 3

`define CRS_RESP_OKAY 2'h0
`define CRS_RESP_SLVERR 2'h2

`endif

// file: hdl/crs_pkg.sv
// Types shared by the call and return sequencer files.
// Assumes nothing of its surroundings.
package crs_pkg;
    typedef enum logic [2:0] {
        CRS_OP_STEP = 3'h0,
        CRS_OP_CALL = 3'h1,
        CRS_OP_EXIT = 3'h2,
        CRS_OP_EXIT_PAGE = 3'h3,
        CRS_OP_EXIT_LIT = 3'h4,
        CRS_OP_IRQ_EXIT = 3'h5,
        CRS_OP_IRQ_EXIT_ADJ = 3'h6,
        CRS_OP_IRQ_ENTRY = 3'h7
    } crs_op_t;

    typedef enum logic [1:0] {
        CRS_ST_IDLE = 2'h0,
        CRS_ST_WAIT1 = 2'h1,
        CRS_ST_WAIT2 = 2'h3
    } crs_state_t;
endpackage : crs_pkg

// file: hdl/crs_stack.sv
// Eight-level shifting return stack with no pointer.
// Assumes push and pop are never asserted together.
`timescale 1ns/1ps
module crs_stack (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic push_in,
    input wire logic pop_in,
    input wire logic two_level_in,
    input wire logic [11:0] push_data_in,
    output logic [11:0] top_out
);
    import crs_pkg::*;
    logic [11:0] ent [0:7];
    integer i;

    assign top_out = ent[0];

    // In two-level use the entries below level two are frozen.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (i = 0; i < 8; i = i + 1) begin
                ent[i] <= 12'h000;
            end
        end else if (push_in) begin
            ent[0] <= push_data_in;
            for (i = 1; i < 8; i = i + 1) begin
                if (!two_level_in || i == 1) begin
                    ent[i] <= ent[i-1];
                end
            end
        end else if (pop_in) begin
            for (i = 0; i < 7; i = i + 1) begin
                if (!two_level_in || i == 0) begin
                    ent[i] <= ent[i+1];
                end
            end
        end
    end

    push_top_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        push_in |=> top_out == $past(push_data_in))
        else $error("Pushed value not on top.");

    pop_bottom_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        pop_in && !two_level_in |=> ent[7] == $past(ent[7]) && ent[6] == $past(ent[7]))
        else $error("Pop did not keep bottom entry.");
endmodule : crs_stack

// file: hdl/crs_seq.sv
// Call and return program-counter sequencer with AXI4-Lite control registers.
// Assumes the core offers one operation at a time and holds it until ready.
`timescale 1ns/1ps
`include "crs_map.svh"
module crs_seq (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic op_valid_in,
    input wire crs_pkg::crs_op_t op_code_in,
    input wire logic [7:0] op_operand_in,
    output logic op_ready_out,
    output logic [11:0] pc_out,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import crs_pkg::*;

    logic [11:0] pc;
    logic [7:0] status;
    logic [7:0] acc;
    logic [7:0] indirect_pointer_reg;
    logic [7:0] real_time_counter_reg;
    logic [2:0] ctrl;
    logic [11:0] save_pc;
    logic [7:0] save_acc;
    logic [7:0] save_status;
    logic [7:0] save_ptr;
    crs_state_t state;
    crs_state_t next_state;
    logic [7:0] aw_addr;
    logic aw_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_held;

    // A narrow counter wraps inside the smaller program memory.
    function automatic logic [11:0] fit_pc(input logic [11:0] v, input logic narrow);
        fit_pc = narrow ? (v & `CRS_PC_NARROW_MASK) : v;
    endfunction : fit_pc

    function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] d,
                                              input logic [3:0] s);
        merge_byte = s[0] ? d[7:0] : old;
    endfunction : merge_byte

    wire narrow = ctrl[`CRS_CTRL_NARROW];
    wire turbo = ctrl[`CRS_CTRL_TURBO];
    wire stack_depth_extend = ctrl[`CRS_CTRL_EXTEND];
    wire [2:0] page_select_bits = status[`CRS_PAGE_HI:`CRS_PAGE_LO];
    wire take = op_valid_in && op_ready_out;
    wire is_call = take && op_code_in == CRS_OP_CALL;
    wire is_sub_exit = take && (op_code_in == CRS_OP_EXIT || op_code_in == CRS_OP_EXIT_PAGE
                                || op_code_in == CRS_OP_EXIT_LIT);
    wire is_irq_exit = take && (op_code_in == CRS_OP_IRQ_EXIT
                                || op_code_in == CRS_OP_IRQ_EXIT_ADJ);
    wire is_irq_entry = take && op_code_in == CRS_OP_IRQ_ENTRY;
    wire is_step = take && op_code_in == CRS_OP_STEP;
    wire [11:0] stack_top;
    wire [11:0] return_addr = fit_pc(pc + 12'h001, narrow);
    wire [11:0] call_target = fit_pc({page_select_bits, 1'b0, op_operand_in}, narrow);
    wire [11:0] popped = fit_pc(stack_top, narrow);

    // The small variant limits the stack unless the extension bit is set.
    wire two_level = narrow && !stack_depth_extend;

    // Only invoke and subroutine exits move the stack; nothing else touches it.
    crs_stack u_stack (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .push_in(is_call),
        .pop_in(is_sub_exit),
        .two_level_in(two_level),
        .push_data_in(return_addr),
        .top_out(stack_top)
    );

    // Bus write decode.
    wire wr_fire = aw_held && w_held && !s_axi_bvalid;
    wire wr_ctrl = wr_fire && aw_addr == `CRS_OFS_CTRL;
    wire wr_status = wr_fire && aw_addr == `CRS_OFS_STATUS;
    wire wr_acc = wr_fire && aw_addr == `CRS_OFS_ACC;
    wire wr_ptr = wr_fire && aw_addr == `CRS_OFS_INDIRECT;
    wire wr_rtc = wr_fire && aw_addr == `CRS_OFS_RTC;
    wire wr_hit = wr_ctrl || wr_status || wr_acc || wr_ptr || wr_rtc
                  || aw_addr == `CRS_OFS_PC;
    wire rd_fire = s_axi_arvalid && s_axi_arready;
    wire rd_hit = s_axi_araddr == `CRS_OFS_CTRL || s_axi_araddr == `CRS_OFS_STATUS
                  || s_axi_araddr == `CRS_OFS_ACC || s_axi_araddr == `CRS_OFS_INDIRECT
                  || s_axi_araddr == `CRS_OFS_RTC || s_axi_araddr == `CRS_OFS_PC;
    wire [31:0] rd_mux =
        s_axi_araddr == `CRS_OFS_CTRL ? {29'h0000000, ctrl} :
        s_axi_araddr == `CRS_OFS_STATUS ? {24'h000000, status} :
        s_axi_araddr == `CRS_OFS_ACC ? {24'h000000, acc} :
        s_axi_araddr == `CRS_OFS_INDIRECT ? {24'h000000, indirect_pointer_reg} :
        s_axi_araddr == `CRS_OFS_RTC ? {24'h000000, real_time_counter_reg} :
        s_axi_araddr == `CRS_OFS_PC ? {20'h00000, pc_out} : 32'h00000000;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign op_ready_out = state == CRS_ST_IDLE;
    assign pc_out = fit_pc(pc, narrow);

    // Invoke holds the core for one extra clock, or two in turbo mode.
    always_comb begin
        next_state = state;
        case (state)
            CRS_ST_IDLE: begin
                if (is_call) begin
                    next_state = turbo ? CRS_ST_WAIT2 : CRS_ST_WAIT1;
                end
            end
            CRS_ST_WAIT2: next_state = CRS_ST_WAIT1;
            CRS_ST_WAIT1: next_state = CRS_ST_IDLE;
            default: next_state = CRS_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= CRS_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pc <= `CRS_PC_RESET;
        end else if (is_call) begin
            pc <= call_target;
        end else if (is_sub_exit) begin
            pc <= popped;
        end else if (is_irq_exit) begin
            pc <= save_pc;
        end else if (is_irq_entry) begin
            pc <= `CRS_PC_IRQ;
        end else if (is_step) begin
            pc <= return_addr;
        end
    end

    // Interrupt context lives in save registers, never on the stack.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            save_pc <= 12'h000;
            save_acc <= 8'h00;
            save_status <= 8'h00;
            save_ptr <= 8'h00;
        end else if (is_irq_entry) begin
            save_pc <= pc_out;
            save_acc <= acc;
            save_status <= status;
            save_ptr <= indirect_pointer_reg;
        end
    end

    // Sequencer updates win over a bus write in the same clock.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            status <= 8'h00;
        end else if (is_irq_exit) begin
            status <= save_status;
        end else if (take && op_code_in == CRS_OP_EXIT_PAGE) begin
            status[`CRS_PAGE_HI:`CRS_PAGE_LO] <= popped[11:9];
        end else if (wr_status) begin
            status <= merge_byte(status, w_data, w_strb);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            acc <= 8'h00;
        end else if (is_irq_exit) begin
            acc <= save_acc;
        end else if (take && op_code_in == CRS_OP_EXIT_LIT) begin
            acc <= op_operand_in;
        end else if (wr_acc) begin
            acc <= merge_byte(acc, w_data, w_strb);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            indirect_pointer_reg <= 8'h00;
        end else if (is_irq_exit) begin
            indirect_pointer_reg <= save_ptr;
        end else if (wr_ptr) begin
            indirect_pointer_reg <= merge_byte(indirect_pointer_reg, w_data, w_strb);
        end
    end

    // The adjustment uses the accumulator as it stood before the restore.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            real_time_counter_reg <= 8'h00;
        end else if (take && op_code_in == CRS_OP_IRQ_EXIT_ADJ) begin
            real_time_counter_reg <= real_time_counter_reg + acc;
        end else if (wr_rtc) begin
            real_time_counter_reg <= merge_byte(real_time_counter_reg, w_data, w_strb);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl <= `CRS_CTRL_RESET;
        end else if (wr_ctrl && w_strb[0]) begin
            ctrl <= w_data[2:0];
        end
    end

    // Address and data are caught independently, in either order.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
            w_held <= 1'b0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CRS_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `CRS_RESP_OKAY : `CRS_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `CRS_RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_hit ? `CRS_RESP_OKAY : `CRS_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    call_target_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        is_call |=> pc == $past(call_target) && pc[8] == 1'b0
                    && pc[11:9] == ($past(page_select_bits) & (narrow ? 3'h3 : 3'h7)))
        else $error("Invoke target wrong.");

    call_push_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        is_call |=> stack_top == fit_pc($past(pc) + 12'h001, $past(narrow)))
        else $error("Invoke pushed wrong return address.");

    call_len_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        is_call && turbo |=> !op_ready_out ##1 !op_ready_out ##1 op_ready_out)
        else $error("Turbo invoke length wrong.");

    call_compat_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        is_call && !turbo |=> !op_ready_out ##1 op_ready_out)
        else $error("Compatible invoke length wrong.");

    exit_pc_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        is_sub_exit |=> pc == $past(popped))
        else $error("Exit did not restore counter.");

    plain_keep_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        take && op_code_in == CRS_OP_EXIT && !wr_fire
        |=> $stable(status) && $stable(acc) && $stable(indirect_pointer_reg)
            && $stable(real_time_counter_reg))
        else $error("Plain exit changed a register.");

    page_exit_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        take && op_code_in == CRS_OP_EXIT_PAGE |=> page_select_bits == pc[11:9])
        else $error("Page exit did not set page bits.");

    lit_exit_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        take && op_code_in == CRS_OP_EXIT_LIT |=> acc == $past(op_operand_in))
        else $error("Literal exit did not load accumulator.");

    irq_exit_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        is_irq_exit |=> pc == $past(save_pc) && acc == $past(save_acc)
                        && status == $past(save_status)
                        && indirect_pointer_reg == $past(save_ptr))
        else $error("Interrupt exit restore wrong.");

    timer_adj_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        take && op_code_in == CRS_OP_IRQ_EXIT_ADJ
        |=> real_time_counter_reg == 8'($past(real_time_counter_reg) + $past(acc)))
        else $error("Timer adjust wrong.");

    irq_stack_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        is_irq_entry || is_irq_exit |=> $stable(stack_top))
        else $error("Interrupt moved the stack.");

    irq_zero_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        is_irq_entry |=> pc_out == `CRS_PC_IRQ)
        else $error("Interrupt entry not at zero.");
endmodule : crs_seq

// file: dv/tb_top.sv
// Self-checking bench for the call and return sequencer.
// Drives the operation port and the register bus itself, with no separate model.
`timescale 1ns/1ps
`include "crs_map.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_top;
    import crs_pkg::*;
    int err_count = 0;
    int compares = 0;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic op_valid_in = 1'b0;
    crs_op_t op_code_in = CRS_OP_STEP;
    logic [7:0] op_operand_in = 8'h00;
    logic op_ready_out;
    logic [11:0] pc_out;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h1;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;

    crs_seq dut (.clk_in, .rst_n_in, .op_valid_in, .op_code_in, .op_operand_in, .op_ready_out,
        .pc_out, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);

    always #20 clk_in = ~clk_in;

    // Ready and valid are looked at on the falling edge, which shows what the next rising
    // edge will sample, so releases land by non-blocking assignment right after that edge.
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er = `CRS_RESP_OKAY);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge clk_in);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(negedge clk_in);
            if (s_axi_awvalid && s_axi_awready === 1'b1) aw_ok = 1'b1;
            if (s_axi_wvalid && s_axi_wready === 1'b1) w_ok = 1'b1;
            @(posedge clk_in);
            if (aw_ok) s_axi_awvalid <= 1'b0;
            if (w_ok) s_axi_wvalid <= 1'b0;
        end
        @(negedge clk_in);
        while (s_axi_bvalid !== 1'b1) @(negedge clk_in);
        `CHK(s_axi_bresp, er)
        @(posedge clk_in);
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er = `CRS_RESP_OKAY);
        @(posedge clk_in);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        @(negedge clk_in);
        while (s_axi_arready !== 1'b1) @(negedge clk_in);
        @(posedge clk_in);
        s_axi_arvalid <= 1'b0;
        @(negedge clk_in);
        while (s_axi_rvalid !== 1'b1) @(negedge clk_in);
        `CHK(s_axi_rdata, e)
        `CHK(s_axi_rresp, er)
        @(posedge clk_in);
        s_axi_rready <= 1'b0;
    endtask : rd

    // Offers one operation, then counts the cycles that ready stays low and checks the counter.
    task automatic op(input crs_op_t c, input logic [7:0] v, input logic [11:0] e,
                      output int low);
        @(posedge clk_in);
        op_valid_in <= 1'b1;
        op_code_in <= c;
        op_operand_in <= v;
        @(negedge clk_in);
        while (op_ready_out !== 1'b1) @(negedge clk_in);
        @(posedge clk_in);
        op_valid_in <= 1'b0;
        low = 0;
        @(negedge clk_in);
        while (op_ready_out !== 1'b1 && low < 8) begin
            low++;
            @(negedge clk_in);
        end
        `CHK(pc_out, e)
    endtask : op

    task automatic t_reset;
        int low;
        @(negedge clk_in);
        `CHK(pc_out, `CRS_PC_RESET)
        `CHK(op_ready_out, 1'b1)
        rd(`CRS_OFS_CTRL, 32'h2);
        rd(`CRS_OFS_STATUS, 32'h0);
        rd(`CRS_OFS_ACC, 32'h0);
        rd(`CRS_OFS_INDIRECT, 32'h0);
        rd(`CRS_OFS_RTC, 32'h0);
        rd(`CRS_OFS_PC, 32'hFFF);
        rd(8'h18, 32'h0, `CRS_RESP_SLVERR);
        op(CRS_OP_EXIT, 8'h00, 12'h000, low);
    endtask : t_reset

    task automatic t_call;
        int low;
        wr(`CRS_OFS_STATUS, 32'h60);
        op(CRS_OP_CALL, 8'hA5, 12'h6A5, low);
        `CHK(low, 1)
        wr(`CRS_OFS_STATUS, 32'h20);
        op(CRS_OP_CALL, 8'h10, 12'h210, low);
        op(CRS_OP_EXIT_PAGE, 8'h00, 12'h6A6, low);
        rd(`CRS_OFS_STATUS, 32'h60);
        wr(`CRS_OFS_ACC, 32'h33);
        op(CRS_OP_EXIT_LIT, 8'h5A, 12'h001, low);
        rd(`CRS_OFS_ACC, 32'h5A);
        op(CRS_OP_CALL, 8'h07, 12'h607, low);
        wr(`CRS_OFS_STATUS, 32'hE0);
        op(CRS_OP_EXIT, 8'h00, 12'h002, low);
        rd(`CRS_OFS_STATUS, 32'hE0);
        rd(`CRS_OFS_ACC, 32'h5A);
    endtask : t_call

    task automatic t_turbo;
        int low;
        wr(`CRS_OFS_CTRL, 32'h3);
        wr(`CRS_OFS_STATUS, 32'h0);
        op(CRS_OP_CALL, 8'h44, 12'h044, low);
        `CHK(low, 2)
        op(CRS_OP_EXIT, 8'h00, 12'h003, low);
        wr(`CRS_OFS_CTRL, 32'h2);
    endtask : t_turbo

    // Nine nested invokes overflow the stack; the oldest address is lost.
    task automatic t_depth;
        int low;
        for (int k = 1; k <= 9; k++) op(CRS_OP_CALL, 8'(k), 12'(k), low);
        for (int k = 9; k >= 2; k--) op(CRS_OP_EXIT, 8'h00, 12'(k), low);
        op(CRS_OP_EXIT, 8'h00, 12'h002, low);
    endtask : t_depth

    task automatic t_narrow;
        int low;
        wr(`CRS_OFS_CTRL, 32'h4);
        wr(`CRS_OFS_STATUS, 32'hE0);
        op(CRS_OP_CALL, 8'h01, 12'h601, low);
        op(CRS_OP_CALL, 8'h02, 12'h602, low);
        op(CRS_OP_CALL, 8'h03, 12'h603, low);
        op(CRS_OP_EXIT, 8'h00, 12'h603, low);
        op(CRS_OP_EXIT, 8'h00, 12'h602, low);
        op(CRS_OP_EXIT, 8'h00, 12'h602, low);
        wr(`CRS_OFS_CTRL, 32'h2);
    endtask : t_narrow

    task automatic t_irq;
        int low;
        wr(`CRS_OFS_ACC, 32'h11);
        wr(`CRS_OFS_STATUS, 32'h40);
        wr(`CRS_OFS_INDIRECT, 32'h22);
        wr(`CRS_OFS_RTC, 32'h30);
        op(CRS_OP_CALL, 8'h08, 12'h408, low);
        op(CRS_OP_IRQ_ENTRY, 8'h00, `CRS_PC_IRQ, low);
        wr(`CRS_OFS_ACC, 32'h05);
        wr(`CRS_OFS_STATUS, 32'h00);
        wr(`CRS_OFS_INDIRECT, 32'h99);
        op(CRS_OP_IRQ_EXIT_ADJ, 8'h00, 12'h408, low);
        rd(`CRS_OFS_ACC, 32'h11);
        rd(`CRS_OFS_STATUS, 32'h40);
        rd(`CRS_OFS_INDIRECT, 32'h22);
        rd(`CRS_OFS_RTC, 32'h35);
        op(CRS_OP_IRQ_ENTRY, 8'h00, `CRS_PC_IRQ, low);
        wr(`CRS_OFS_ACC, 32'h07);
        op(CRS_OP_IRQ_EXIT, 8'h00, 12'h408, low);
        rd(`CRS_OFS_ACC, 32'h11);
        rd(`CRS_OFS_RTC, 32'h35);
        wr(`CRS_OFS_PC, 32'h123);
        rd(`CRS_OFS_PC, 32'h408);
        op(CRS_OP_EXIT, 8'h00, 12'h603, low);
        op(CRS_OP_STEP, 8'h00, 12'h604, low);
    endtask : t_irq

    task automatic end_sim;
        $display("mismatches %0d comparisons %0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim

    initial begin
        repeat (20) @(posedge clk_in);
        rst_n_in <= 1'b1;
        t_reset();
        t_call();
        t_turbo();
        t_depth();
        t_narrow();
        t_irq();
        end_sim();
    end

    // The tests need a few hundred cycles; twenty thousand means something hung.
    initial begin
        #800000;
        err_count++;
        end_sim();
    end
endmodule : tb_top
